//--- src/stpt_defs.vh
`ifndef STPT_DEFS_VH
`define STPT_DEFS_VH

// register offsets on the internal register port
`define STPT_ADDR_IDLE_LEN 8'h37
`define STPT_ADDR_DECIM 8'h38
`define STPT_RST_IDLE_LEN 8'h00
`define STPT_RST_DECIM 8'h00

// field positions
`define STPT_IDLE_MSB 4
`define STPT_IDLE_LSB 0
`define STPT_DEC_MSB 3
`define STPT_DEC_LSB 0

// timing: clock period and idle-phase step, both in ns
`define STPT_CLK_PERIOD_NS 4
`define STPT_IDLE_STEP_NS 31250
// idle base of 312.5 us counted in idle steps
`define STPT_IDLE_BASE_STEPS 10
// cycles in two idle steps (31.25 us is a half cycle off the grid)
`define STPT_IDLE_STEP2_CYC ((2 * `STPT_IDLE_STEP_NS) / `STPT_CLK_PERIOD_NS)

// decimation cap: codes above this code select the same sample count
`define STPT_DEC_CAP_CODE 4'hc

// axis choice value that disengages self-test
`define STPT_AXIS_OFF 2'h0
// power mode forced while self-test runs
`define STPT_ST_PWR_MODE 2'h0

`endif

//--- src/stpt_cfg_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "stpt_defs.vh"

// holds the two self-test configuration registers; read data registered
module stpt_cfg_regs (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  output reg [7:0] idle_len_q,
  output reg [7:0] decim_q
);

  // writes store all eight bits; upper bits are plain read/write storage
  always @(posedge mclk) begin
    if (rst) begin
      idle_len_q <= `STPT_RST_IDLE_LEN;
      decim_q <= `STPT_RST_DECIM;
    end else if (reg_wr) begin
      if (reg_addr == `STPT_ADDR_IDLE_LEN) begin
        idle_len_q <= reg_wdata;
      end else if (reg_addr == `STPT_ADDR_DECIM) begin
        decim_q <= reg_wdata;
      end
    end
  end

  // read returns zero for addresses this block does not own
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `STPT_ADDR_IDLE_LEN) begin
        reg_rdata_q <= idle_len_q;
      end else if (reg_addr == `STPT_ADDR_DECIM) begin
        reg_rdata_q <= decim_q;
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

endmodule // stpt_cfg_regs

`default_nettype wire

//--- src/stpt_phase_timing.v
`timescale 1ns/1ps
`default_nettype none
`include "stpt_defs.vh"

module stpt_phase_timing #(
  parameter [31:0] IDLE_STEP2_CYC = `STPT_IDLE_STEP2_CYC
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [1:0] selftest_axis_choice,
  input wire [3:0] user_odr,
  input wire [1:0] user_pwr,
  output reg [7:0] reg_rdata_q,
  output reg st_active_q,
  output reg st_meas_q,
  output reg st_dir_q,
  output reg [1:0] st_axis_q,
  output reg sample_tick_q,
  output reg meas_done_q,
  output reg [31:0] selftest_meas_period_q,
  output reg [3:0] eff_odr_q,
  output reg [1:0] eff_pwr_q
);

  // sequencer states
  localparam [1:0] S_OFF = 2'h0;
  localparam [1:0] S_IDLE = 2'h1;
  localparam [1:0] S_MEAS = 2'h2;

  // register outputs and the live fields that act
  wire [7:0] idle_len_w;
  wire [7:0] decim_w;
  wire [7:0] rdata_w;
  wire [4:0] selftest_idle_count;
  wire [3:0] selftest_decim_code;

  // phase counters; durations are held per phase in idle_cyc_q
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] idle_cyc_q;
  reg [12:0] samples_q;
  reg [31:0] cnt_q;
  reg [12:0] smp_cnt_q;

  // configuration storage sits in its own module
  stpt_cfg_regs u_regs (
    .mclk(mclk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(rdata_w),
    .idle_len_q(idle_len_w),
    .decim_q(decim_w)
  );

  // only the low field bits act; the upper bits are plain storage
  assign selftest_idle_count = idle_len_w[`STPT_IDLE_MSB:`STPT_IDLE_LSB];
  assign selftest_decim_code = decim_w[`STPT_DEC_MSB:`STPT_DEC_LSB];

  // idle length in cycles, a least time so the half cycle rounds up
  function [31:0] idle_cycles;
    input [4:0] n;
    reg [31:0] steps;
    begin
      steps = `STPT_IDLE_BASE_STEPS + {27'h0, n};
      idle_cycles = (steps * IDLE_STEP2_CYC + 32'h1) >> 1;
    end
  endfunction

  // sample count for a decimation code, clamped at the cap
  function [12:0] dec_samples;
    input [3:0] code;
    reg [3:0] c;
    begin
      c = (code > `STPT_DEC_CAP_CODE) ? `STPT_DEC_CAP_CODE : code;
      dec_samples = 13'h1 << c;
    end
  endfunction

  // next state: any non-zero axis choice engages the sequence;
  // a disengage wins over any phase end in the same cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      S_OFF: begin
        if (selftest_axis_choice != `STPT_AXIS_OFF) begin
          state_d = S_IDLE;
        end
      end
      S_IDLE: begin
        if (selftest_axis_choice == `STPT_AXIS_OFF) begin
          state_d = S_OFF;
        end else if (cnt_q == 32'h1) begin
          state_d = S_MEAS;
        end
      end
      S_MEAS: begin
        if (selftest_axis_choice == `STPT_AXIS_OFF) begin
          state_d = S_OFF;
        end else if (cnt_q == 32'h1 && smp_cnt_q == 13'h1) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_OFF;
      end
    endcase
  end

  // phase sequencer; settings are latched afresh at every idle start so
  // a write mid-phase takes effect from the next idle start, not part way through a phase
  always @(posedge mclk) begin
    if (rst) begin
      state_q <= S_OFF;
      idle_cyc_q <= 32'h0;
      samples_q <= 13'h0;
      cnt_q <= 32'h0;
      smp_cnt_q <= 13'h0;
      st_dir_q <= 1'b0;
      st_axis_q <= 2'h0;
      sample_tick_q <= 1'b0;
      meas_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sample_tick_q <= 1'b0;
      meas_done_q <= 1'b0;
      if (state_d == S_IDLE && state_q != S_IDLE) begin
        idle_cyc_q <= idle_cycles(selftest_idle_count);
        cnt_q <= idle_cycles(selftest_idle_count);
        samples_q <= dec_samples(selftest_decim_code);
        st_axis_q <= selftest_axis_choice;
        if (state_q == S_OFF) begin
          st_dir_q <= 1'b0;
        end
      end else if (state_q == S_IDLE && state_d == S_MEAS) begin
        // each sample slot spans one idle duration
        cnt_q <= idle_cyc_q;
        smp_cnt_q <= samples_q;
      end else if (state_q == S_MEAS && state_d == S_MEAS) begin
        // reload for the next sample slot
        if (cnt_q == 32'h1) begin
          cnt_q <= idle_cyc_q;
          smp_cnt_q <= smp_cnt_q - 13'h1;
          sample_tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h1;
        end
      end else if (state_q == S_IDLE) begin
        cnt_q <= cnt_q - 32'h1;
      end
      if (state_q == S_MEAS && state_d == S_IDLE) begin
        sample_tick_q <= 1'b1;
        meas_done_q <= 1'b1;
        st_dir_q <= ~st_dir_q;
      end
      if (state_d == S_OFF) begin
        cnt_q <= 32'h0;
        smp_cnt_q <= 13'h0;
      end
    end
  end

  // a live preview of the settings, one cycle behind a write; the
  // sequencer itself runs on the values latched at idle start
  // period equals samples times idle
  always @(posedge mclk) begin
    if (rst) begin
      selftest_meas_period_q <= 32'h0;
    end else begin
      selftest_meas_period_q <= idle_cycles(selftest_idle_count) *
        {19'h0, dec_samples(selftest_decim_code)};
    end
  end

  // the override follows state_d so it switches on the same edge as
  // st_active_q and the sensing core never sees a mixed setting
  // status flags and the mode override seen by the sensing core
  always @(posedge mclk) begin
    if (rst) begin
      st_active_q <= 1'b0;
      st_meas_q <= 1'b0;
      eff_odr_q <= 4'h0;
      eff_pwr_q <= 2'h0;
      reg_rdata_q <= 8'h00;
    end else begin
      st_active_q <= (state_d != S_OFF);
      st_meas_q <= (state_d == S_MEAS);
      reg_rdata_q <= rdata_w;
      if (state_d != S_OFF) begin
        eff_odr_q <= selftest_decim_code;
        eff_pwr_q <= `STPT_ST_PWR_MODE;
      end else begin
        eff_odr_q <= user_odr;
        eff_pwr_q <= user_pwr;
      end
    end
  end

endmodule // stpt_phase_timing

`default_nettype wire

//--- sim/stpt_phase_timing_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module stpt_phase_timing_asserts #(
  parameter [31:0] IDLE_STEP2_CYC = 32'h4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [1:0] selftest_axis_choice,
  input wire logic [3:0] user_odr,
  input wire logic [1:0] user_pwr,
  input wire logic st_active_q,
  input wire logic st_meas_q,
  input wire logic st_dir_q,
  input wire logic [1:0] st_axis_q,
  input wire logic sample_tick_q,
  input wire logic meas_done_q,
  input wire logic [31:0] selftest_meas_period_q,
  input wire logic [3:0] eff_odr_q,
  input wire logic [1:0] eff_pwr_q
);
  logic [4:0] idl_q;
  logic [3:0] dec_q;
  logic [31:0] icnt_q, mcnt_q;
  // odd step products round up by half a cycle
  wire [31:0] exp_i = (({27'h0, idl_q} + 32'ha) * IDLE_STEP2_CYC + 32'h1) / 32'h2;
  wire [31:0] exp_p = exp_i << ((dec_q > 4'hc) ? 4'hc : dec_q);
  // shadow fields and phase length counters
  always @(posedge mclk) begin
    if (rst) begin
      idl_q <= 5'h0;
      dec_q <= 4'h0;
    end else if (reg_wr && reg_addr == 8'h37) begin
      idl_q <= reg_wdata[4:0];
    end else if (reg_wr && reg_addr == 8'h38) begin
      dec_q <= reg_wdata[3:0];
    end
    icnt_q <= (!rst && st_active_q && !st_meas_q) ? icnt_q + 32'h1 : 32'h0;
    mcnt_q <= (!rst && st_meas_q) ? mcnt_q + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence engage_s;
    !st_active_q && selftest_axis_choice != 2'h0;
  endsequence
  sequence idle_end_s;
    $rose(st_meas_q);
  endsequence
  engage_start_a: assert property (engage_s |=> st_active_q)
    else $error("self-test did not start");
  disengage_stop_a: assert property (selftest_axis_choice == 2'h0 |=>
    !st_active_q && !st_meas_q) else $error("self-test did not stop");
  idle_length_a: assert property (idle_end_s |-> icnt_q == exp_i)
    else $error("idle length wrong");
  meas_length_a: assert property ($fell(st_meas_q) && st_active_q |->
    mcnt_q == exp_p) else $error("measurement length wrong");
  period_value_a: assert property (st_meas_q |->
    selftest_meas_period_q == exp_p) else $error("period output wrong");
  done_at_end_a: assert property ($fell(st_meas_q) && st_active_q |->
    meas_done_q && sample_tick_q) else $error("end pulse missing");
  tick_spacing_a: assert property (sample_tick_q |->
    mcnt_q % exp_i == 32'h0) else $error("sample slot length wrong");
  eff_override_a: assert property (st_active_q |-> eff_pwr_q == 2'h0 &&
    eff_odr_q == dec_q) else $error("user settings not overridden");
  eff_restore_a: assert property (!st_active_q && !$past(st_active_q) &&
    !$past(rst) && $stable(user_odr) && $stable(user_pwr) |->
    eff_odr_q == user_odr && eff_pwr_q == user_pwr)
    else $error("user settings not restored");
  dir_first_a: assert property (engage_s |=> !st_dir_q)
    else $error("direction not cleared on engage");
  dir_toggle_a: assert property ($fell(st_meas_q) && st_active_q |->
    st_dir_q != $past(st_dir_q)) else $error("direction did not alternate");
  axis_latch_a: assert property ($rose(st_active_q) |->
    st_axis_q == $past(selftest_axis_choice)) else $error("axis not latched");
endmodule // stpt_phase_timing_asserts
bind stpt_phase_timing stpt_phase_timing_asserts #(
  .IDLE_STEP2_CYC(IDLE_STEP2_CYC)) u_chk (.mclk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .selftest_axis_choice, .user_odr, .user_pwr, .st_active_q,
  .st_meas_q, .st_dir_q, .st_axis_q, .sample_tick_q, .meas_done_q,
  .selftest_meas_period_q,
  .eff_odr_q, .eff_pwr_q);
`default_nettype wire

//--- sim/test_stpt_phase_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_stpt_phase_timing;
  localparam [31:0] STEP = 32'h4;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, meas_d = 1'b0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, b;
  logic [1:0] axis = 2'h0, user_pwr = 2'h0;
  logic [3:0] user_odr = 4'h0, d;
  logic [1:0] rdp = 2'h0;
  logic [7:0] rq[$];
  logic [31:0] pq[$];
  logic [31:0] i_exp;
  integer seed = 32'ha9086274;
  int num_errors = 0, n_checks = 0, k, t;
  wire [7:0] reg_rdata_q;
  wire [31:0] per_q;
  wire [3:0] eff_odr_q;
  wire st_active_q, st_meas_q, meas_done_q;
  stpt_phase_timing #(.IDLE_STEP2_CYC(STEP)) u_stpt_phase_timing (.mclk(mclk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .selftest_axis_choice(axis), .user_odr(user_odr),
    .user_pwr(user_pwr), .reg_rdata_q(reg_rdata_q), .st_active_q(st_active_q),
    .st_meas_q(st_meas_q), .st_dir_q(), .st_axis_q(), .sample_tick_q(),
    .meas_done_q(meas_done_q), .selftest_meas_period_q(per_q),
    .eff_odr_q(eff_odr_q), .eff_pwr_q());
  // free-running clock, 4 ns period
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one compare task per kind of result
  task automatic chk_rdata(input logic [7:0] e);
    n_checks++;
    if (reg_rdata_q !== e) begin
      num_errors++;
      $display("[FAIL] reg_rdata_q exp %h got %h", e, reg_rdata_q);
    end
  endtask
  task automatic chk_period(input logic [31:0] e);
    n_checks++;
    if (per_q !== e) begin
      num_errors++;
      $display("[FAIL] selftest_meas_period_q exp %h got %h", e, per_q);
    end
  endtask
  // bounded wait: 0 for measurement start, 1 for measurement end
  task automatic wait_on(input int which);
    for (t = 0; t < 20000; t++) begin
      @(negedge mclk);
      if ((which == 0) ? st_meas_q === 1'b1 : meas_done_q === 1'b1) return;
    end
    num_errors++;
    tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // one idle cycle so back-to-back calls never re-assign the strobe
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
  endtask
  // read data shows on the output one edge after the taking edge
  always @(posedge mclk) rdp <= {rdp[0], reg_rd};
  // monitor: compare oldest note when a result shows
  always @(negedge mclk) begin
    if (rdp[1]) chk_rdata(rq.pop_front());
    if (st_meas_q === 1'b1 && !meas_d && pq.size() > 0)
      chk_period(pq.pop_front());
    meas_d = (st_meas_q === 1'b1);
  end
  // main sequence; last pass uses the top decimation code
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    rd(8'h37, 8'h00);
    rd(8'h38, 8'h00);
    wr(8'h5a, 8'hff);
    rd(8'h5a, 8'h00);
    for (k = 0; k < 4; k++) begin
      b = $random(seed);
      d = (k == 3) ? 4'hf : k[3:0];
      wr(8'h37, b);
      wr(8'h38, {b[7:4], d});
      rd(8'h37, b);
      rd(8'h38, {b[7:4], d});
      i_exp = (({27'h0, b[4:0]} + 32'ha) * STEP + 32'h1) / 32'h2;
      pq.push_back(i_exp << ((d > 4'hc) ? 4'hc : d));
      user_odr = $random(seed);
      axis = 2'(k % 3 + 1);
      user_pwr = $random(seed);
      wait_on(0);
      if (k < 3) begin
        wait_on(1);
        wait_on(1);
      end
      axis = 2'h0;
      repeat (3) @(negedge mclk);
    end
    tally_and_finish();
  end
endmodule // test_stpt_phase_timing
`default_nettype wire
